/* File: lpps_pkg.sv */
// Package of constants and types for the panel power sequencer
// Summary of operation
// - Reset keeps panel enable high (off)
// - Panel-select high forces panel enable off
// - Panel enable low after two frame strobes
// - Backlight enable follows panel-select immediately
// - Supplies-good low forces both enables off
// - Power-down pair forces both enables off immediately
// - Leaving power-down waits two frame strobes
// - CRT mode keeps both enables off throughout
// - Controller drives panel-select from mode bit 4
// - CRT-to-panel switch software step order
// - Panel-to-CRT switch software step order
// - Both enables are active low outputs
// - Board supplies good, power-down pair, reset
package lpps_pkg;
  localparam int unsigned LPPS_STROBES = 2;
  localparam logic [1:0] LPPS_CNT_RESET = 2'h0;
  localparam int unsigned LPPS_PANEL_BIT = 4;
  localparam int unsigned LPPS_CRT_BIT = 5;
  localparam logic [7:0] LPPS_MODE_RESET = 8'h20;
  localparam int unsigned LPPS_FRAME_DIV = 16;
  localparam logic [3:0] LPPS_FRAME_LAST = 4'hf;
  typedef enum logic [2:0] {
    LPPS_IDLE,
    LPPS_CLR_CRT,
    LPPS_SAVE,
    LPPS_SHADOW,
    LPPS_RESTORE,
    LPPS_SET_BIT
  } lpps_step_t;
endpackage

/* File: lpps_if.sv */
// Interface joining the board controller end and the sequencer end
`timescale 1ns/100ps
`default_nettype none
interface lpps_if;
  logic supplies_good;
  logic powerdown_n;
  logic powerdown_p;
  logic board_reset;
  logic panel_select_n;
  logic frame_pulse;
  logic line_pulse;
  logic panel_power_enable_n;
  logic backlight_enable_n;
  modport seq (
    input supplies_good, powerdown_n, powerdown_p, board_reset,
    input panel_select_n, frame_pulse, line_pulse,
    output panel_power_enable_n, backlight_enable_n
  );
  modport board (
    output supplies_good, powerdown_n, powerdown_p, board_reset,
    output panel_select_n, frame_pulse, line_pulse,
    input panel_power_enable_n, backlight_enable_n
  );
endinterface
`default_nettype wire

/* File: lpps_board.sv */
// Board side: supplies, power-down pair, reset, controller mode steps
`timescale 1ns/100ps
`default_nettype none
module lpps_board (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic SUPPLIES_GOOD_I,
  input wire logic POWERDOWN_REQ_I,
  input wire logic PANEL_MODE_REQ_I,
  output logic BUSY_O,
  output logic [7:0] DISPLAY_MODE_REG_O,
  lpps_if.board lnk
);
  logic [7:0] mode_q, mode_d;
  lpps_pkg::lpps_step_t step_q, step_d;
  logic busy_q, busy_d;
  logic [3:0] div_q, div_d;
  logic fp_q, fp_d, lp_q, lp_d;
  logic good_q, pd_q, rst_q;

  always_comb begin
    mode_d = mode_q;
    step_d = step_q;
    busy_d = 1'b1;
    case (step_q)
      lpps_pkg::LPPS_IDLE: begin
        busy_d = 1'b0;
        if (PANEL_MODE_REQ_I != mode_q[lpps_pkg::LPPS_PANEL_BIT]) begin
          busy_d = 1'b1;
          step_d = lpps_pkg::LPPS_CLR_CRT;
        end
      end
      lpps_pkg::LPPS_CLR_CRT: begin
        // Clear the mode bit being left first
        if (PANEL_MODE_REQ_I) begin
          mode_d[lpps_pkg::LPPS_CRT_BIT] = 1'b0;
        end else begin
          mode_d[lpps_pkg::LPPS_PANEL_BIT] = 1'b0;
        end
        step_d = lpps_pkg::LPPS_SAVE;
      end
      lpps_pkg::LPPS_SAVE: step_d = lpps_pkg::LPPS_SHADOW;
      lpps_pkg::LPPS_SHADOW: step_d = lpps_pkg::LPPS_RESTORE;
      lpps_pkg::LPPS_RESTORE: step_d = lpps_pkg::LPPS_SET_BIT;
      lpps_pkg::LPPS_SET_BIT: begin
        if (PANEL_MODE_REQ_I) begin
          mode_d[lpps_pkg::LPPS_PANEL_BIT] = 1'b1;
        end else begin
          mode_d[lpps_pkg::LPPS_CRT_BIT] = 1'b1;
        end
        step_d = lpps_pkg::LPPS_IDLE;
      end
      default: step_d = lpps_pkg::LPPS_IDLE;
    endcase
  end

  // Frame and line pulses stop in power-down, as the controller does
  always_comb begin
    div_d = pd_q ? 4'h0 : div_q + 4'h1;
    fp_d = !pd_q && (div_q == lpps_pkg::LPPS_FRAME_LAST);
    lp_d = !pd_q && div_q[0];
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      mode_q <= lpps_pkg::LPPS_MODE_RESET;
      step_q <= lpps_pkg::LPPS_IDLE;
      busy_q <= 1'b0;
      div_q <= 4'h0;
      fp_q <= 1'b0;
      lp_q <= 1'b0;
      good_q <= 1'b0;
      pd_q <= 1'b0;
      rst_q <= 1'b1;
    end else begin
      mode_q <= mode_d;
      step_q <= step_d;
      busy_q <= busy_d;
      div_q <= div_d;
      fp_q <= fp_d;
      lp_q <= lp_d;
      good_q <= SUPPLIES_GOOD_I;
      pd_q <= POWERDOWN_REQ_I;
      rst_q <= 1'b0;
    end
  end

  assign BUSY_O = busy_q;
  assign DISPLAY_MODE_REG_O = mode_q;
  assign lnk.supplies_good = good_q;
  assign lnk.powerdown_n = !pd_q;
  assign lnk.powerdown_p = pd_q;
  assign lnk.board_reset = rst_q;
  assign lnk.panel_select_n = !mode_q[lpps_pkg::LPPS_PANEL_BIT];
  assign lnk.frame_pulse = fp_q;
  assign lnk.line_pulse = lp_q;
endmodule
`default_nettype wire

/* File: lpps_seq.sv */
// Panel power sequencer: panel and backlight enables
`timescale 1ns/100ps
`default_nettype none
module lpps_seq (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  lpps_if.seq lnk,
  output logic PANEL_ON_O,
  output logic BACKLIGHT_ON_O
);
  logic [1:0] cnt_q, cnt_d;
  logic fp_q;
  logic lcd_n_q, lcd_n_d;
  logic bl_n_q, bl_n_d;
  // Separate flops so the status outputs come straight from registers
  logic panel_on_q, light_on_q;
  logic hold_off;
  logic strobe;

  // Any off condition keeps the panel dark and restarts the strobe count
  always_comb begin
    hold_off = lnk.board_reset
      || lnk.panel_select_n
      || !lnk.supplies_good
      || !lnk.powerdown_n || lnk.powerdown_p;
    strobe = lnk.frame_pulse && !fp_q;
    cnt_d = cnt_q;
    if (hold_off) begin
      cnt_d = lpps_pkg::LPPS_CNT_RESET;
    end else if (strobe && cnt_q != 2'(lpps_pkg::LPPS_STROBES)) begin
      cnt_d = cnt_q + 2'h1;
    end
    lcd_n_d = hold_off || (cnt_d != 2'(lpps_pkg::LPPS_STROBES));
    // Backlight ignores the strobe count
    bl_n_d = hold_off;
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      cnt_q <= lpps_pkg::LPPS_CNT_RESET;
      fp_q <= 1'b0;
      lcd_n_q <= 1'b1;
      bl_n_q <= 1'b1;
      panel_on_q <= 1'b0;
      light_on_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      fp_q <= lnk.frame_pulse;
      lcd_n_q <= lcd_n_d;
      bl_n_q <= bl_n_d;
      panel_on_q <= !lcd_n_d;
      light_on_q <= !bl_n_d;
    end
  end

  assign lnk.panel_power_enable_n = lcd_n_q;
  assign lnk.backlight_enable_n = bl_n_q;
  assign PANEL_ON_O = panel_on_q;
  assign BACKLIGHT_ON_O = light_on_q;
endmodule
`default_nettype wire

/* File: lpps_checker.sv */
// Checker of the panel power link
`timescale 1ns/100ps
`default_nettype none
module lpps_checker (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic supplies_good,
  input wire logic powerdown_n,
  input wire logic powerdown_p,
  input wire logic board_reset,
  input wire logic panel_select_n,
  input wire logic frame_pulse,
  input wire logic line_pulse,
  input wire logic panel_power_enable_n,
  input wire logic backlight_enable_n
);
  logic [5:0] run_q;
  logic [1:0] seen_q;
  logic fp_seen_q;
  wire off = board_reset | panel_select_n | !supplies_good | !powerdown_n | powerdown_p;
  wire pe = panel_power_enable_n;
  wire be = backlight_enable_n;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Saturating count of cycles allowed on, since strobes are too slow to bound by repetition
  always_ff @(posedge CLK_I) begin
    run_q <= (off || !RST_N_I) ? 6'h0 : run_q + 6'(run_q != 6'h3f);
  end
  // Own count of frame strobes since the panel was last forced off
  always_ff @(posedge CLK_I) begin
    fp_seen_q <= frame_pulse;
    if (off || !RST_N_I) begin
      seen_q <= 2'h0;
    end else if (frame_pulse && !fp_seen_q && seen_q != 2'h2) begin
      seen_q <= seen_q + 2'h1;
    end
  end
  reset_off_a: assert property (board_reset |=> pe) else $error("panel on in reset");
  select_off_a: assert property (panel_select_n |=> pe && be) else $error("crt on");
  supply_off_a: assert property (!supplies_good |=> pe && be) else $error("supply on");
  powerdown_p_off_a: assert property (!powerdown_n || powerdown_p |=> pe && be) else $error("pd on");
  light_on_a: assert property (!off |=> !be) else $error("light late");
  panel_wait_a: assert property ($fell(off) |=> pe [*8]) else $error("panel early");
  panel_on_a: assert property (run_q > 6'h28 |-> !pe) else $error("panel late");
  strobe_count_a: assert property ($fell(pe) |-> seen_q == 2'h2) else $error("panel too soon");
  pulse_live_a: assert property (!pe |-> line_pulse != $past(line_pulse)) else $error("pulses idle");
  panel_light_a: assert property (!pe |-> !be) else $error("panel alone");
endmodule
`default_nettype wire

/* File: lpps_tb.sv */
// Testbench joining board and sequencer ends
`timescale 1ns/100ps
`default_nettype none
module lpps_tb;
  logic clk, rst_n, sg, pd, pm, busy, p_on, b_on;
  logic [7:0] mode;
  logic [4:0] q[$];
  logic [3:0] e;
  logic [2:0] r;
  int fail_count, check_count, k, n;
  event got;
  // Each entry: supply, power-down, panel mode, then panel, light, mode bits 4 and 5
  logic [6:0] tbl [8] = '{7'h41, 7'h5e, 7'h72, 7'h5e, 7'h12, 7'h5e, 7'h41, 7'h61};
  lpps_if lnk ();
  lpps_board lpps_board_i (.CLK_I(clk), .RST_N_I(rst_n), .SUPPLIES_GOOD_I(sg),
    .POWERDOWN_REQ_I(pd), .PANEL_MODE_REQ_I(pm), .BUSY_O(busy),
    .DISPLAY_MODE_REG_O(mode), .lnk(lnk));
  lpps_seq lpps_seq_i (.CLK_I(clk), .RST_N_I(rst_n), .lnk(lnk), .PANEL_ON_O(p_on),
    .BACKLIGHT_ON_O(b_on));
  lpps_checker lpps_checker_i (.CLK_I(clk), .RST_N_I(rst_n),
    .supplies_good(lnk.supplies_good), .powerdown_n(lnk.powerdown_n),
    .powerdown_p(lnk.powerdown_p), .board_reset(lnk.board_reset),
    .panel_select_n(lnk.panel_select_n), .frame_pulse(lnk.frame_pulse),
    .line_pulse(lnk.line_pulse), .panel_power_enable_n(lnk.panel_power_enable_n),
    .backlight_enable_n(lnk.backlight_enable_n));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  always @(got) begin
    check_count++;
    if ({busy, p_on, b_on, mode[4], mode[5]} !== q[0]) begin
      fail_count++;
      $display("unexpected at %0t: got %b want %b", $time,
        {busy, p_on, b_on, mode[4], mode[5]}, q[0]);
    end
    void'(q.pop_front());
  end
  task automatic note(input logic [4:0] x);
    q.push_back(x);
    -> got;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Worst case is far below this span
  initial begin
    #50000;
    fail_count++;
    give_verdict;
  end
  initial begin
    rst_n = 0;
    sg = 0;
    pd = 0;
    pm = 0;
    void'($urandom(32'hceaf));
    repeat (2) @(posedge clk);
    rst_n <= 1;
    foreach (tbl[i]) begin
      @(posedge clk);
      {sg, pd, pm} <= tbl[i][6:4];
      if (tbl[i][6:4] == 3'b101) begin
        for (k = 0; k < 40 && b_on !== 1'b1; k++) @(negedge clk);
        note(5'b00110);
      end
      repeat (40 + $urandom % 20) @(posedge clk);
      @(negedge clk);
      note({1'b0, tbl[i][3:0]});
      $display("test %0d done", i);
    end
    // Random mixes of supply, power-down and mode, each held until settled
    e = tbl[7][3:0];
    for (n = 0; n < 24; n++) begin
      @(posedge clk);
      r = 3'($urandom);
      {sg, pd, pm} <= r;
      if (r[0] != e[1]) begin
        repeat (2) @(negedge clk);
        note({1'b1, e});
      end
      repeat (60) @(posedge clk);
      @(negedge clk);
      e = {r[2] && !r[1] && r[0], r[2] && !r[1] && r[0], r[0], !r[0]};
      note({1'b0, e});
    end
    $display("test random done");
    // Reset in mid-run with the panel lit must drop it, then the switch restarts
    @(posedge clk);
    {sg, pd, pm} <= 3'b101;
    repeat (60) @(posedge clk);
    @(negedge clk);
    note(5'b01110);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    note(5'b00001);
    repeat (60) @(posedge clk);
    @(negedge clk);
    note(5'b01110);
    $display("test reset done");
    give_verdict;
  end
endmodule
`default_nettype wire
